// [include/queue_ctrl_pkg.sv]
/*
  types of the queue control register bank. assumes nothing outside.
*/
package queue_ctrl_pkg;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_INV_NS_GUEST = 3'h1,
    CMD_INV_HYP = 3'h2,
    CMD_INV_MONITOR = 3'h3,
    CMD_INV_S_GUEST = 3'h4,
    CMD_INV_CONFIG = 3'h5,
    CMD_SYNC = 3'h6
  } command_e;

  typedef enum logic [1:0] {
    Q_OFF = 2'b00,
    Q_STARTING = 2'b01,
    Q_ON = 2'b10,
    Q_STOPPING = 2'b11
  } queue_state_e;
endpackage : queue_ctrl_pkg

// [include/queue_ctrl_regs.svh]
/*
  register offsets, field positions, reset values and nanosecond timings of the
  queue control register bank. assumes inclusion by bare name.
*/
`ifndef QUEUE_CTRL_REGS_SVH
`define QUEUE_CTRL_REGS_SVH

`define ADDR_W 8
`define OFF_CMDQ_BASE 8'h00
`define OFF_CMDQ_RD 8'h04
`define OFF_CMDQ_WR 8'h08
`define OFF_EVTQ_BASE 8'h0C
`define OFF_EVTQ_RD 8'h10
`define OFF_EVTQ_WR 8'h14
`define OFF_STRTAB_CFG 8'h18
`define OFF_STRTAB_BASE 8'h1C
`define OFF_CTRL 8'h20
`define OFF_ACK 8'h24
`define OFF_INIT 8'h28
`define OFF_ID 8'h2C
`define OFF_CMD 8'h30
`define OFF_STATUS 8'h34
`define OFF_SECURE_ACCESS 8'h38
`define OFF_STE_VALID 8'h3C

`define BASE_SIZE_LSB 0
`define BASE_SIZE_W 5
`define BASE_ADDR_LSB 5
`define CTRL_CMDQ_EN_BIT 0
`define CTRL_EVTQ_EN_BIT 1
`define INIT_GLOBAL_INVALIDATE_BIT_BIT 0
`define ID_COHACC_BIT 0
`define CMD_OP_LSB 0
`define CMD_OP_W 3
`define CMD_SEC_BIT 3
`define SACC_SCR_BIT 0

`define RST_ZERO 32'h0000_0000
`define MAX_SIZE_LOG2 5'h13

`define QUEUE_SWITCH_NS 40
`define INVALIDATE_NS 80
`define CLK_PERIOD_NS 10
`endif

// [src/queue_ctrl_bank.sv]
/*
  control register bank: queue base/index registers, stream table setup,
  queue enable handshake, invalidation commands, global invalidate.
  assumes a single-cycle register port master on clk_i; sec_override_i is
  a pin and is synchronised here.
*/
// Design decisions made here: the address map and the plain strobed port.
//
// Function
// [RQ1] queue size field limits writable bits of read and write indices
// [RQ2] software programs size and base before touching indices
// [RQ3] queue is empty when read index equals write index
// [RQ4] software clears both indices of both queues to zero at init; the bench clears them in the secure world only
// [RQ5] software writes table format, then table base address
// [RQ6] invalid stream entries are never used as configuration
// [RQ7] coherent access support is reported in an identification bit
// [RQ8] software makes memory writes visible with a barrier first
// [RQ9] command queue enable is reflected in acknowledge once started
// [RQ10] event queue enable is reflected in acknowledge once started
// [RQ11] software invalidates all caches before translation use
// [RQ12] four invalidate-all TLB commands, one per context
// [RQ13] secure TLB invalidation acts only from the secure command queue
// [RQ14] secure software issues the first TLB invalidation
// [RQ15] non-secure access to secure init allowed by override or control
// [RQ16] config invalidate clears walk config cache and buffer caches
// [RQ17] sync completes only after all earlier commands complete
// [RQ18] global invalidate clears everything then self-clears
// [RQ19] software polls global invalidate until zero
// [RQ20] separate secure and non-secure worlds with own registers
// [RQ21] acknowledge updates only after queue fully starts or stops
`timescale 1ns/1ps
`default_nettype none
`include "queue_ctrl_regs.svh"
module queue_ctrl_bank #(
  parameter int MAX_LOG2 = `MAX_SIZE_LOG2,
  parameter bit COHERENT_ACCESS = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic secure_i,
  input wire logic sec_override_i,
  input wire logic [5:0] ste_index_i,
  output logic [31:0] rdata_o,
  output logic ste_usable_o,
  output logic [6:0] inv_pulse_o,
  output logic busy_o
);
  localparam int QSW = (`QUEUE_SWITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int INVC = (`INVALIDATE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  logic rst_s1_r, rst_n;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  logic ovr_s1_r, ovr_r;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ovr_s1_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      ovr_s1_r <= sec_override_i;
      ovr_r <= ovr_s1_r;
    end
  end

  // index mask from the log2 size field; clamped to the implemented maximum
  function automatic logic [31:0] idx_mask(input logic [31:0] base);
    logic [4:0] sz;
    sz = base[`BASE_SIZE_LSB +: `BASE_SIZE_W];
    if (sz > 5'(MAX_LOG2)) sz = 5'(MAX_LOG2);
    idx_mask = (32'h0000_0001 << (sz + 5'h01)) - 32'h0000_0001;
  endfunction : idx_mask

  // two worlds: index 0 non-secure, index 1 secure
  logic [31:0] cq_base_r [2], cq_rd_r [2], cq_wr_r [2];
  logic [31:0] eq_base_r [2], eq_rd_r [2], eq_wr_r [2];
  logic [31:0] st_cfg_r [2], st_base_r [2];
  logic [1:0] ctrl_r [2];
  wire [1:0] ack [2];
  logic [63:0] ste_valid_r;
  logic scr_r;
  logic global_invalidate_bit_r;
  logic [7:0] inv_cnt_r;
  logic [6:0] pend_r;
  logic [7:0] cmd_cnt_r;
  logic sync_wait_r;
  logic [31:0] rdata_nxt;

  wire w = secure_i; // [RQ20]
  wire init_ok = secure_i || ovr_r || scr_r; // [RQ15]
  wire sel_base_c = (addr_i == `OFF_CMDQ_BASE);
  wire sel_rd_c = (addr_i == `OFF_CMDQ_RD);
  wire sel_wr_c = (addr_i == `OFF_CMDQ_WR);
  wire sel_base_e = (addr_i == `OFF_EVTQ_BASE);
  wire sel_rd_e = (addr_i == `OFF_EVTQ_RD);
  wire sel_wr_e = (addr_i == `OFF_EVTQ_WR);
  wire sel_stcfg = (addr_i == `OFF_STRTAB_CFG);
  wire sel_stbase = (addr_i == `OFF_STRTAB_BASE);
  wire sel_ctrl = (addr_i == `OFF_CTRL);
  wire sel_init = (addr_i == `OFF_INIT);
  wire sel_cmd = (addr_i == `OFF_CMD);
  wire sel_sacc = (addr_i == `OFF_SECURE_ACCESS);
  wire sel_ste = (addr_i == `OFF_STE_VALID);
  wire [31:0] cmask = idx_mask(cq_base_r[w]); // [RQ1]
  wire [31:0] emask = idx_mask(eq_base_r[w]); // [RQ1]
  wire cq_empty = (cq_rd_r[w] == cq_wr_r[w]); // [RQ3]
  wire eq_empty = (eq_rd_r[w] == eq_wr_r[w]); // [RQ3]

  wire [2:0] cmd_op = wdata_i[`CMD_OP_LSB +: `CMD_OP_W];
  wire cmd_go = wr_i && sel_cmd && ctrl_r[w][`CTRL_CMDQ_EN_BIT];
  // secure-guest invalidation is dropped from the non-secure queue [RQ13]
  wire cmd_ok = cmd_go && !(cmd_op == queue_ctrl_pkg::CMD_INV_S_GUEST && !secure_i);
  wire inv_start = wr_i && sel_init && init_ok && wdata_i[`INIT_GLOBAL_INVALIDATE_BIT_BIT] && !global_invalidate_bit_r;

  genvar g;
  for (g = 0; g < 2; g++) begin : g_world
    queue_enable_handshake #(.SWITCH_CYCLES(QSW)) u_cmdq (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .enable_i(ctrl_r[g][`CTRL_CMDQ_EN_BIT]),
      .ack_o(ack[g][0])
    ); // [RQ9]
    queue_enable_handshake #(.SWITCH_CYCLES(QSW)) u_evtq (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .enable_i(ctrl_r[g][`CTRL_EVTQ_EN_BIT]),
      .ack_o(ack[g][1])
    ); // [RQ10]
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        cq_base_r[i] <= `RST_ZERO;
        cq_rd_r[i] <= `RST_ZERO;
        cq_wr_r[i] <= `RST_ZERO;
        eq_base_r[i] <= `RST_ZERO;
        eq_rd_r[i] <= `RST_ZERO;
        eq_wr_r[i] <= `RST_ZERO;
        st_cfg_r[i] <= `RST_ZERO;
        st_base_r[i] <= `RST_ZERO;
        ctrl_r[i] <= 2'b00;
      end
      scr_r <= 1'b0;
      ste_valid_r <= 64'h0;
    end else if (wr_i) begin
      if (sel_base_c) cq_base_r[w] <= wdata_i;
      else if (sel_rd_c) cq_rd_r[w] <= wdata_i & cmask; // [RQ1]
      else if (sel_wr_c) cq_wr_r[w] <= wdata_i & cmask; // [RQ1]
      else if (sel_base_e) eq_base_r[w] <= wdata_i;
      else if (sel_rd_e) eq_rd_r[w] <= wdata_i & emask; // [RQ1]
      else if (sel_wr_e) eq_wr_r[w] <= wdata_i & emask; // [RQ1]
      else if (sel_stcfg) st_cfg_r[w] <= wdata_i;
      else if (sel_stbase) st_base_r[w] <= wdata_i;
      else if (sel_ctrl) ctrl_r[w] <= wdata_i[1:0];
      else if (sel_sacc && secure_i) scr_r <= wdata_i[`SACC_SCR_BIT];
      else if (sel_ste) ste_valid_r[wdata_i[13:8]] <= wdata_i[0];
    end
  end

  // global invalidate: set by software, cleared by hardware on completion [RQ18]
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      global_invalidate_bit_r <= 1'b0;
      inv_cnt_r <= 8'h00;
    end else if (inv_start) begin
      global_invalidate_bit_r <= 1'b1;
      inv_cnt_r <= 8'(INVC);
    end else if (global_invalidate_bit_r) begin
      inv_cnt_r <= inv_cnt_r - 8'h01;
      if (inv_cnt_r == 8'h01) global_invalidate_bit_r <= 1'b0; // [RQ18]
    end
  end

  // queued commands: all finish together INVC cycles after the latest one; sync waits for all of them [RQ17]
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 7'h00;
      cmd_cnt_r <= 8'h00;
      sync_wait_r <= 1'b0;
      inv_pulse_o <= 7'h00;
    end else begin
      inv_pulse_o <= 7'h00;
      if (cmd_cnt_r != 8'h00) cmd_cnt_r <= cmd_cnt_r - 8'h01;
      if (cmd_cnt_r == 8'h01) begin
        inv_pulse_o <= pend_r; // [RQ12] [RQ16]
        pend_r <= 7'h00;
      end
      if (sync_wait_r && cmd_cnt_r <= 8'h01) sync_wait_r <= 1'b0; // [RQ17]
      if (global_invalidate_bit_r && inv_cnt_r == 8'h01) inv_pulse_o <= 7'h7F; // [RQ18]
      if (cmd_ok) begin
        case (cmd_op)
          queue_ctrl_pkg::CMD_INV_NS_GUEST,
          queue_ctrl_pkg::CMD_INV_HYP,
          queue_ctrl_pkg::CMD_INV_MONITOR,
          queue_ctrl_pkg::CMD_INV_S_GUEST: begin
            pend_r[cmd_op] <= 1'b1; // [RQ12]
            cmd_cnt_r <= 8'(INVC);
          end
          queue_ctrl_pkg::CMD_INV_CONFIG: begin
            pend_r[5] <= 1'b1; // [RQ16]
            cmd_cnt_r <= 8'(INVC);
          end
          queue_ctrl_pkg::CMD_SYNC: sync_wait_r <= (cmd_cnt_r > 8'h01); // [RQ17]
          default: ;
        endcase
      end
    end
  end

  wire [31:0] status_w = {26'h0, sync_wait_r, global_invalidate_bit_r, eq_empty, cq_empty, (cmd_cnt_r != 8'h00), 1'b0};
  wire [31:0] id_w = {31'h0, COHERENT_ACCESS}; // [RQ7]

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (sel_base_c) rdata_nxt = cq_base_r[w];
    else if (sel_rd_c) rdata_nxt = cq_rd_r[w];
    else if (sel_wr_c) rdata_nxt = cq_wr_r[w];
    else if (sel_base_e) rdata_nxt = eq_base_r[w];
    else if (sel_rd_e) rdata_nxt = eq_rd_r[w];
    else if (sel_wr_e) rdata_nxt = eq_wr_r[w];
    else if (sel_stcfg) rdata_nxt = st_cfg_r[w];
    else if (sel_stbase) rdata_nxt = st_base_r[w];
    else if (sel_ctrl) rdata_nxt = {30'h0, ctrl_r[w]};
    else if (addr_i == `OFF_ACK) rdata_nxt = {30'h0, ack[w]}; // [RQ9] [RQ10]
    else if (sel_init && init_ok) rdata_nxt = {31'h0, global_invalidate_bit_r}; // [RQ15]
    else if (addr_i == `OFF_ID) rdata_nxt = id_w;
    else if (addr_i == `OFF_STATUS) rdata_nxt = status_w;
    else if (sel_sacc) rdata_nxt = {31'h0, scr_r};
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 32'h0000_0000;
      ste_usable_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      rdata_o <= rd_i ? rdata_nxt : 32'h0000_0000;
      ste_usable_o <= ste_valid_r[ste_index_i]; // [RQ6]
      busy_o <= global_invalidate_bit_r || (cmd_cnt_r != 8'h00) || sync_wait_r;
    end
  end

  a_inv_self_clear: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ18]
    $rose(global_invalidate_bit_r) |-> ##[1:20] !global_invalidate_bit_r)
    else $error("global invalidate never cleared");

  a_ns_secure_drop: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ13]
    cmd_go && !secure_i && cmd_op == queue_ctrl_pkg::CMD_INV_S_GUEST && cmd_cnt_r == 8'h00 |=> !pend_r[4])
    else $error("secure invalidation taken from non-secure queue");

  a_ack_cmdq: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ9]
    $rose(ctrl_r[0][0]) |-> ##[1:8] ack[0][0])
    else $error("command queue ack late");

  a_ack_evtq: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ10]
    $rose(ctrl_r[1][1]) |-> ##[1:8] ack[1][1])
    else $error("event queue ack late");

  a_index_masked: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ1]
    wr_i && sel_wr_c |=> (cq_wr_r[$past(w)] & ~$past(cmask)) == 32'h0)
    else $error("index bits beyond size");

  a_empty_flag: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ3]
    rd_i && addr_i == `OFF_STATUS && cq_rd_r[w] == cq_wr_r[w] |=> rdata_o[2])
    else $error("empty flag wrong");

  a_cohacc_id: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ7]
    rd_i && addr_i == `OFF_ID |=> rdata_o[0] == COHERENT_ACCESS)
    else $error("coherent bit wrong");

  a_ste_invalid: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ6]
    !ste_valid_r[ste_index_i] |=> !ste_usable_o)
    else $error("invalid entry used");

  a_sync_order: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ17]
    sync_wait_r |-> cmd_cnt_r != 8'h00)
    else $error("sync finished before earlier commands");

  a_init_gate: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ15]
    wr_i && sel_init && !secure_i && !ovr_r && !scr_r && !global_invalidate_bit_r |=> !global_invalidate_bit_r)
    else $error("non-secure init write not blocked");

  a_cmdq_rd_masked: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ1]
    wr_i && sel_rd_c |=> (cq_rd_r[$past(w)] & ~$past(cmask)) == 32'h0)
    else $error("read index bits beyond size");

  a_evtq_wr_masked: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ1]
    wr_i && sel_wr_e |=> (eq_wr_r[$past(w)] & ~$past(emask)) == 32'h0)
    else $error("event write index bits beyond size");

  a_empty_clear: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ3]
    rd_i && addr_i == `OFF_STATUS && cq_rd_r[w] != cq_wr_r[w] |=> !rdata_o[2])
    else $error("command queue shown empty while holding entries");

  a_evtq_empty_read: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ3]
    rd_i && addr_i == `OFF_STATUS && eq_rd_r[w] == eq_wr_r[w] |=> rdata_o[3])
    else $error("event queue empty flag wrong");

  a_ste_valid_used: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ6]
    ste_valid_r[ste_index_i] |=> ste_usable_o)
    else $error("valid entry not usable");

  a_pulse_after_count: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ12]
    cmd_cnt_r == 8'h01 && pend_r != 7'h00 |=> inv_pulse_o != 7'h00)
    else $error("pending invalidation not issued");

  a_config_pulse: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ16]
    cmd_ok && cmd_op == queue_ctrl_pkg::CMD_INV_CONFIG |=> pend_r[5])
    else $error("config invalidate not queued");

  a_secure_cmd_kept: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ13]
    cmd_ok && cmd_op == queue_ctrl_pkg::CMD_INV_S_GUEST |=> pend_r[4])
    else $error("secure invalidation lost");

  a_sync_held: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ17]
    cmd_ok && cmd_op == queue_ctrl_pkg::CMD_SYNC && cmd_cnt_r > 8'h01 |=> sync_wait_r)
    else $error("sync did not wait for earlier commands");

  a_global_invalidate_bit_pulse: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ18]
    global_invalidate_bit_r && inv_cnt_r == 8'h01 |=> inv_pulse_o == 7'h7F && !global_invalidate_bit_r)
    else $error("global invalidate end wrong");

  a_global_invalidate_bit_busy: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ18]
    global_invalidate_bit_r |=> busy_o)
    else $error("busy low during global invalidate");

  a_ack_secure_cmdq: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ9]
    $rose(ctrl_r[1][0]) |-> ##[1:8] ack[1][0])
    else $error("secure command queue ack late");

  a_init_read_gate: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ15]
    rd_i && sel_init && !init_ok |=> rdata_o == 32'h0000_0000)
    else $error("non-secure init read not blocked");

  a_world_split: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ20]
    wr_i && sel_base_c && !secure_i |=> $stable(cq_base_r[1]))
    else $error("non-secure write reached secure copy");
endmodule : queue_ctrl_bank
`default_nettype wire

// [src/queue_enable_handshake.sv]
/*
  enable / acknowledge handshake for one queue.
  assumes synchronous reset copy and same clock as the register bank.
*/
`timescale 1ns/1ps
`default_nettype none
`include "queue_ctrl_regs.svh"
module queue_enable_handshake #(
  parameter int SWITCH_CYCLES = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  output logic ack_o
);
  localparam int CW = $clog2(SWITCH_CYCLES + 1);
  queue_ctrl_pkg::queue_state_e state_r, state_nxt;
  logic [CW-1:0] cnt_r;
  wire done = (cnt_r == CW'(SWITCH_CYCLES - 1));

  // ack moves only once the queue has fully started or stopped [RQ21]
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      queue_ctrl_pkg::Q_OFF: if (enable_i) state_nxt = queue_ctrl_pkg::Q_STARTING;
      queue_ctrl_pkg::Q_STARTING: if (done) state_nxt = queue_ctrl_pkg::Q_ON;
      queue_ctrl_pkg::Q_ON: if (!enable_i) state_nxt = queue_ctrl_pkg::Q_STOPPING;
      queue_ctrl_pkg::Q_STOPPING: if (done) state_nxt = queue_ctrl_pkg::Q_OFF;
      default: state_nxt = queue_ctrl_pkg::Q_OFF;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= queue_ctrl_pkg::Q_OFF;
      cnt_r <= '0;
      ack_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt != state_r) ? '0 : (done ? cnt_r : cnt_r + CW'(1));
      ack_o <= (state_nxt == queue_ctrl_pkg::Q_ON) || (state_nxt == queue_ctrl_pkg::Q_STOPPING);
    end
  end

  a_ack_waits: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ21]
    $rose(enable_i) && !ack_o |=> !ack_o)
    else $error("ack rose together with enable");
endmodule : queue_enable_handshake
`default_nettype wire

// [tb/tb_top.sv]
/*
  self-checking bench for the queue control register bank: register
  port tasks, queue handshake, commands and global invalidate.
  assumes the register offsets header and the package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "queue_ctrl_regs.svh"
module tb_top;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [`ADDR_W-1:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic secure_i = 1'b0;
  logic sec_override_i = 1'b0;
  logic [5:0] ste_index_i = '0;
  logic [31:0] rdata_o;
  logic ste_usable_o;
  logic [6:0] inv_pulse_o;
  logic busy_o;
  logic [6:0] seen = '0;
  int errors = 0;
  int num_checks = 0;

  queue_ctrl_bank dut (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .secure_i(secure_i),
    .sec_override_i(sec_override_i),
    .ste_index_i(ste_index_i),
    .rdata_o(rdata_o),
    .ste_usable_o(ste_usable_o),
    .inv_pulse_o(inv_pulse_o),
    .busy_o(busy_o)
  );

  always #5 clk_i = ~clk_i;

  // pulses last one cycle, so they are gathered here and judged later
  always @(posedge clk_i) seen <= seen | inv_pulse_o;

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    secure_i <= s;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic s, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    secure_i <= s;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic s, input logic [31:0] m, input logic [31:0] e,
                    input string msg);
    logic [31:0] v;
    rd(a, s, v);
    chk(v & m, e, msg);
  endtask : rc

  // bounded poll; running out of tries ends the run as a mismatch
  task automatic poll(input logic [7:0] a, input logic s, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    int i;
    for (i = 0; i < 30; i++) begin
      rd(a, s, v);
      if ((v & m) === e) break;
    end
    chk(v & m, e, "poll");
    if (i == 30) wrap_up();
  endtask : poll

  task automatic cmd(input logic [2:0] op, input logic s, input logic [6:0] e, input string msg);
    #1 seen = '0;
    wr(`OFF_CMD, {29'h0, op}, s);
    cyc(12);
    chk({25'h0, seen}, {25'h0, e}, msg);
  endtask : cmd

  task automatic stream_table_entry(input logic [5:0] idx, input logic val);
    wr(`OFF_STE_VALID, {18'h0, idx, 7'h0, val}, 1'b1);
    ste_index_i <= idx;
    cyc(2);
    #1 chk({31'h0, ste_usable_o}, {31'h0, val}, "entry usable");
  endtask : stream_table_entry

  initial begin
    #200000;
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    cyc(8);
    reset_n_i <= 1'b1;
    cyc(3);
    rc(8'h40, 1'b1, 32'hFFFF_FFFF, `RST_ZERO, "unmapped");
    rc(`OFF_ACK, 1'b1, 32'hFFFF_FFFF, `RST_ZERO, "ack reset");
    rc(`OFF_ID, 1'b0, 32'h1, 32'h1, "coherent id");
    // sizes first, indices after, as software must do
    wr(`OFF_CMDQ_BASE, 32'h0000_1002, 1'b1);
    wr(`OFF_EVTQ_BASE, 32'h0000_2003, 1'b1);
    wr(`OFF_CMDQ_BASE, 32'h0000_001F, 1'b0);
    wr(`OFF_CMDQ_RD, 32'hFFFF_FFFF, 1'b1);
    wr(`OFF_EVTQ_WR, 32'hFFFF_FFFF, 1'b1);
    wr(`OFF_CMDQ_RD, 32'hFFFF_FFFF, 1'b0);
    rc(`OFF_CMDQ_RD, 1'b1, 32'hFFFF_FFFF, 32'h7, "cmdq index mask");
    rc(`OFF_EVTQ_WR, 1'b1, 32'hFFFF_FFFF, 32'hF, "evtq index mask");
    rc(`OFF_CMDQ_RD, 1'b0, 32'hFFFF_FFFF, 32'h000F_FFFF, "size clamp");
    wr(`OFF_CMDQ_RD, 32'h0, 1'b1);
    wr(`OFF_CMDQ_WR, 32'h0, 1'b1);
    wr(`OFF_EVTQ_RD, 32'h0, 1'b1);
    wr(`OFF_EVTQ_WR, 32'h0, 1'b1);
    rc(`OFF_CMDQ_RD, 1'b1, 32'hFFFF_FFFF, 32'h0, "cleared index");
    rc(`OFF_CMDQ_RD, 1'b0, 32'hFFFF_FFFF, 32'h000F_FFFF, "worlds apart");
    rc(`OFF_STATUS, 1'b1, 32'hC, 32'hC, "both empty");
    wr(`OFF_CMDQ_WR, 32'h1, 1'b1);
    rc(`OFF_STATUS, 1'b1, 32'hC, 32'h8, "cmdq not empty");
    wr(`OFF_EVTQ_RD, 32'h5, 1'b1);
    rc(`OFF_STATUS, 1'b1, 32'hC, 32'h0, "evtq not empty");
    wr(`OFF_CMDQ_WR, 32'h0, 1'b1);
    wr(`OFF_EVTQ_RD, 32'h0, 1'b1);
    wr(`OFF_STRTAB_CFG, 32'h0000_0006, 1'b1);
    wr(`OFF_STRTAB_BASE, 32'h0000_4000, 1'b1);
    stream_table_entry(6'h05, 1'b0);
    stream_table_entry(6'h05, 1'b1);
    stream_table_entry(6'h3F, 1'b0);
    stream_table_entry(6'h05, 1'b0);
    // writes are visible at once here, so no barrier wait is modelled
    cyc(2);
    wr(`OFF_CTRL, 32'h1, 1'b1);
    rc(`OFF_ACK, 1'b1, 32'h1, 32'h0, "ack early");
    poll(`OFF_ACK, 1'b1, 32'h1, 32'h1);
    wr(`OFF_CTRL, 32'h3, 1'b1);
    rc(`OFF_ACK, 1'b1, 32'h3, 32'h1, "evtq ack early");
    poll(`OFF_ACK, 1'b1, 32'h2, 32'h2);
    cmd(3'h1, 1'b0, 7'h00, "queue off");
    wr(`OFF_CTRL, 32'h1, 1'b0);
    poll(`OFF_ACK, 1'b0, 32'h1, 32'h1);
    cmd(3'h4, 1'b1, 7'h10, "first tlb inval secure");
    for (int op = 1; op <= 5; op++) begin
      cmd(op[2:0], 1'b1, 7'h01 << op, "inval cmd");
    end
    cmd(3'h7, 1'b1, 7'h00, "unknown op");
    cmd(3'h4, 1'b0, 7'h00, "ns secure inval");
    cmd(3'h1, 1'b0, 7'h02, "ns guest inval");
    #1 seen = '0;
    wr(`OFF_CMD, 32'h1, 1'b1);
    wr(`OFF_CMD, 32'h6, 1'b1);
    rc(`OFF_STATUS, 1'b1, 32'h20, 32'h20, "sync waiting");
    chk({31'h0, busy_o}, 32'h1, "busy in flight");
    poll(`OFF_STATUS, 1'b1, 32'h22, 32'h0);
    chk({31'h0, busy_o}, 32'h0, "busy idle");
    chk({25'h0, seen}, 32'h2, "prior cmd done");
    #1 seen = '0;
    wr(`OFF_INIT, 32'h1, 1'b1);
    rc(`OFF_INIT, 1'b1, 32'h1, 32'h1, "global_invalidate_bit set");
    chk({31'h0, busy_o}, 32'h1, "busy global_invalidate_bit");
    rc(`OFF_INIT, 1'b0, 32'h1, 32'h0, "ns init hidden");
    poll(`OFF_INIT, 1'b1, 32'h1, 32'h0);
    chk({25'h0, seen}, 32'h7F, "global_invalidate_bit pulses");
    wr(`OFF_INIT, 32'h1, 1'b0);
    rc(`OFF_INIT, 1'b1, 32'h1, 32'h0, "ns init refused");
    cyc(1);
    sec_override_i <= 1'b1;
    cyc(4);
    wr(`OFF_INIT, 32'h1, 1'b0);
    rc(`OFF_INIT, 1'b0, 32'h1, 32'h1, "override grant");
    poll(`OFF_INIT, 1'b1, 32'h1, 32'h0);
    cyc(1);
    sec_override_i <= 1'b0;
    cyc(4);
    wr(`OFF_SECURE_ACCESS, 32'h1, 1'b0);
    wr(`OFF_INIT, 32'h1, 1'b0);
    rc(`OFF_INIT, 1'b1, 32'h1, 32'h0, "scr needs secure");
    wr(`OFF_SECURE_ACCESS, 32'h1, 1'b1);
    wr(`OFF_INIT, 32'h1, 1'b0);
    rc(`OFF_INIT, 1'b0, 32'h1, 32'h1, "scr grant");
    poll(`OFF_INIT, 1'b1, 32'h1, 32'h0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
